/* File: pkg/lam_pkg.sv */
// lam_pkg: constants and types of the local adjust menu block
// assumes a 10 MHz clock and a 32-bit classic wishbone register port
package lam_pkg;
   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int CLK_KHZ = 10000;
   localparam int ADV_MS = 3000;
   localparam int ADV_CYC = ADV_MS * CLK_KHZ;
   localparam int STEP_MS = 100;
   localparam int STEP_CYC = STEP_MS * CLK_KHZ;
   localparam int DEB_MS = 10;
   localparam int DEB_CYC = DEB_MS * CLK_KHZ;
   localparam int ALT_MS = 2000;
   localparam int ALT_CYC = ALT_MS * CLK_KHZ;
   // -----------------------------------------------------------
   // register map and fields
   // -----------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_VAL0 = 8'h08;
   localparam logic [7:0] REG_DISP = 8'h18;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_WP_BIT = 1;
   localparam int STAT_ACT_BIT = 0;
   localparam int STAT_CHO_BIT = 1;
   localparam int STAT_RMP_BIT = 2;
   localparam int STAT_POS_LSB = 4;
   localparam int STAT_CAND_LSB = 8;
   localparam int DISP_D1_LSB = 0;
   localparam int DISP_D2_LSB = 4;
   localparam int DISP_UNIT_LSB = 8;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic CTRL_WP_RST = 1'b0;
   localparam logic [7:0] UNIT_RST = 8'h00;
   // value index: 0 lower range, 1 upper range, 2 probe, 3 ref height
   localparam logic [3:0][15:0] VAL_RST =
      {16'h0BB8, 16'h0BB8, 16'h03E8, 16'h0000};
   localparam logic [3:0][15:0] VAL_MIN_DEF =
      {16'h0000, 16'h0064, 16'h0000, 16'h0000};
   localparam logic [3:0][15:0] VAL_MAX_DEF =
      {16'h3A98, 16'h3A98, 16'h3A98, 16'h3A98};
   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_MENU = 2'b01,
      MODE_CHOOSE = 2'b10
   } lam_mode_t;
   typedef enum logic [3:0] {
      POS_UNITS = 4'b0000,
      POS_DISP1 = 4'b0001,
      POS_DISP2 = 4'b0010,
      POS_LRV_UP = 4'b0011,
      POS_LRV_DN = 4'b0100,
      POS_URV_UP = 4'b0101,
      POS_URV_DN = 4'b0110,
      POS_PL_UP = 4'b0111,
      POS_PL_DN = 4'b1000,
      POS_RH_UP = 4'b1001,
      POS_RH_DN = 4'b1010,
      POS_SAVE = 4'b1011,
      POS_EXIT = 4'b1100
   } lam_pos_t;
   typedef enum logic [2:0] {
      SHOW_OUTPUT_CURRENT = 3'b000,
      SHOW_OUTPUT_PERCENT = 3'b001,
      SHOW_DISTANCE_FROM_TOP = 3'b010,
      SHOW_PRODUCT_LEVEL = 3'b011,
      SHOW_PRODUCT_VOLUME = 3'b100,
      SHOW_AMBIENT_TEMPERATURE = 3'b101,
      SHOW_NOTHING = 3'b110
   } lam_disp_t;
   typedef struct packed {
      logic [7:0] units;
      lam_disp_t first_display_select;
      lam_disp_t second_display_select;
      logic [3:0][15:0] val;
   } lam_settings_t;
endpackage

/* File: logic/lam_debounce.sv */
// lam_debounce: synchroniser and debouncer for one reed switch
// assumes an asynchronous, bouncing level on sw_i
`timescale 1ns/1ps
`default_nettype none
module lam_debounce #(
   parameter int unsigned DEB_CYC = lam_pkg::DEB_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sw_i,
   output logic level_o
);
   // ---------------------------------------------------------
   // three-stage sync, then a stability count
   // ---------------------------------------------------------
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic [31:0] cnt_q;
   // only stages two and three are looked at
   wire differ = (s2_q == s3_q) && (s3_q != level_o);
   wire done = cnt_q == 32'(DEB_CYC - 1);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         cnt_q <= 32'h0;
         level_o <= 1'b0;
      end
      else if (ce_i)
      begin
         s1_q <= sw_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         cnt_q <= (differ && !done) ? cnt_q + 32'h1 : 32'h0;
         if (differ && done)
            level_o <= s3_q;
      end
   end
endmodule
`default_nettype wire

/* File: logic/lam_menu.sv */
// lam_menu: local adjust menu driven by browse and select switches
// assumes 10 MHz clk_i, synchronous reset, classic wishbone master
//
// How it works
// - browse steps units, displays, eight ramps, save, exit, then wraps
// - select in display one opens a list; browse cycles, select commits
// - display one takes one of six variable codes
// - display two uses the same select, browse, select commit sequence
// - display two adds a seventh code meaning nothing shown
// - indicator alternates between at most the two chosen variables
// - lower range rises while select held, stops on release or maximum
// - lower range falls while select held, stops on release or minimum
// - upper range rises while select held, stops on release or maximum
// - upper range falls while select held, stops on release or minimum
// - probe length rises while select held, stops at release or maximum
// - probe length falls while select held, stops at release or minimum
// - reference height rises while select held, stops at maximum
// - reference height falls while select held, stops at minimum
// - the parameter being adjusted is shown in the numeric field
// - every local change acts at once, without a save
// - changes live only in volatile flops until saved
// - select in save writes all seven settings to nonvolatile memory
// - select in exit returns to normal measurement display
// - browse in normal state enters the menu
// - holding browse advances the function about every three seconds
// - local enable off ignores both switches
// - write protect refuses local and remote configuration changes
`timescale 1ns/1ps
`default_nettype none
module lam_menu #(
   parameter int unsigned ADV_CYC = lam_pkg::ADV_CYC,
   parameter int unsigned STEP_CYC = lam_pkg::STEP_CYC,
   parameter int unsigned DEB_CYC = lam_pkg::DEB_CYC,
   parameter int unsigned ALT_CYC = lam_pkg::ALT_CYC,
   parameter logic [3:0][15:0] VAL_MIN = lam_pkg::VAL_MIN_DEF,
   parameter logic [3:0][15:0] VAL_MAX = lam_pkg::VAL_MAX_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic browse_sw_i,
   input wire logic select_sw_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output lam_pkg::lam_settings_t settings_o,
   output logic nvm_save_o,
   output lam_pkg::lam_settings_t nvm_data_o,
   output logic menu_active_o,
   output lam_pkg::lam_pos_t menu_pos_o,
   output logic choosing_o,
   output lam_pkg::lam_disp_t choice_o,
   output logic [15:0] numeric_o,
   output logic numeric_valid_o,
   output lam_pkg::lam_disp_t disp_show_o
);
   // ---------------------------------------------------------
   // switch conditioning
   // ---------------------------------------------------------
   logic brw, sel, brw_q, sel_q;
   lam_debounce #(.DEB_CYC(DEB_CYC)) u_brw (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .sw_i(browse_sw_i),
      .level_o(brw)
   );
   lam_debounce #(.DEB_CYC(DEB_CYC)) u_sel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .sw_i(select_sw_i),
      .level_o(sel)
   );

   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   lam_pkg::lam_mode_t mode_q, mode_d;
   lam_pkg::lam_pos_t pos_q, pos_d;
   lam_pkg::lam_disp_t cand_q, cand_d, d1_q, d2_q;
   logic [7:0] unit_q;
   logic [3:0][15:0] val_q;
   logic en_q, wp_q, slot_q;
   logic [31:0] hold_q, step_q, alt_q;
   wire ev_b = brw && !brw_q && en_q;
   wire ev_s = sel && !sel_q && !brw && en_q;
   wire in_idle = mode_q == lam_pkg::MODE_IDLE;
   wire in_menu = mode_q == lam_pkg::MODE_MENU;
   wire in_cho = mode_q == lam_pkg::MODE_CHOOSE;
   wire adv_tick = brw && en_q && !in_idle
      && hold_q == 32'(ADV_CYC - 1);
   wire adv = ev_b || adv_tick;
   wire is_d1 = pos_q == lam_pkg::POS_DISP1;
   wire is_d2 = pos_q == lam_pkg::POS_DISP2;
   wire at_save = pos_q == lam_pkg::POS_SAVE;
   wire at_exit = pos_q == lam_pkg::POS_EXIT;
   wire [3:0] pos_inc = at_exit ? lam_pkg::POS_UNITS : pos_q + 4'h1;
   // list length differs: display two offers the extra blank code
   wire [2:0] cand_max = is_d2 ? lam_pkg::SHOW_NOTHING
      : lam_pkg::SHOW_AMBIENT_TEMPERATURE;
   wire [2:0] cand_inc = (cand_q == cand_max) ? 3'h0 : cand_q + 3'h1;
   wire commit = in_cho && ev_s && !wp_q;
   wire do_save = in_menu && ev_s && at_save;
   // ---------------------------------------------------------
   // ramp decode
   // ---------------------------------------------------------
   wire is_ramp = pos_q >= lam_pkg::POS_LRV_UP && pos_q <= lam_pkg::POS_RH_DN;
   wire [3:0] pos_off = pos_q - lam_pkg::POS_LRV_UP;
   wire [1:0] ridx = pos_off[2:1];
   wire rup = !pos_off[0];
   wire ramp_act = en_q && in_menu && is_ramp && sel && !brw;
   wire ramp_tick = ramp_act && step_q == 32'h0;
   wire step_end = step_q == 32'(STEP_CYC - 1);
   // ---------------------------------------------------------
   // menu sequencing
   // ---------------------------------------------------------
   always_comb
   begin
      mode_d = mode_q;
      pos_d = pos_q;
      cand_d = cand_q;
      unique case (mode_q)
         lam_pkg::MODE_IDLE:
            if (ev_b)
            begin
               mode_d = lam_pkg::MODE_MENU;
               pos_d = lam_pkg::POS_UNITS;
            end
         lam_pkg::MODE_MENU:
            if (adv)
               pos_d = lam_pkg::lam_pos_t'(pos_inc);
            else if (ev_s && at_exit)
               mode_d = lam_pkg::MODE_IDLE;
            else if (ev_s && (is_d1 || is_d2))
            begin
               mode_d = lam_pkg::MODE_CHOOSE;
               cand_d = is_d2 ? d2_q : d1_q;
            end
         lam_pkg::MODE_CHOOSE:
            if (adv)
               cand_d = lam_pkg::lam_disp_t'(cand_inc);
            else if (ev_s)
               mode_d = lam_pkg::MODE_MENU;
         default:
            mode_d = lam_pkg::MODE_IDLE;
      endcase
      if (!en_q)
         mode_d = lam_pkg::MODE_IDLE;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_q <= lam_pkg::MODE_IDLE;
         pos_q <= lam_pkg::POS_UNITS;
         cand_q <= lam_pkg::SHOW_OUTPUT_CURRENT;
         brw_q <= 1'b0;
         sel_q <= 1'b0;
         hold_q <= 32'h0;
         step_q <= 32'h0;
      end
      else if (ce_i)
      begin
         mode_q <= mode_d;
         pos_q <= pos_d;
         cand_q <= cand_d;
         brw_q <= brw;
         sel_q <= sel;
         hold_q <= (!brw || in_idle || adv_tick) ? 32'h0
            : hold_q + 32'h1;
         step_q <= (!ramp_act || step_end) ? 32'h0
            : step_q + 32'h1;
      end
   end

   // ---------------------------------------------------------
   // register bus
   // ---------------------------------------------------------
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = req && wb_we_i;
   wire [31:0] bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] ctrl_rd = 32'(en_q) << lam_pkg::CTRL_EN_BIT
      | 32'(wp_q) << lam_pkg::CTRL_WP_BIT;
   wire [31:0] disp_rd = 32'(d1_q) << lam_pkg::DISP_D1_LSB
      | 32'(d2_q) << lam_pkg::DISP_D2_LSB
      | 32'(unit_q) << lam_pkg::DISP_UNIT_LSB;
   wire [31:0] stat_rd = 32'(!in_idle) << lam_pkg::STAT_ACT_BIT
      | 32'(in_cho) << lam_pkg::STAT_CHO_BIT
      | 32'(ramp_act) << lam_pkg::STAT_RMP_BIT
      | 32'(pos_q) << lam_pkg::STAT_POS_LSB
      | 32'(cand_q) << lam_pkg::STAT_CAND_LSB;
   wire [31:0] ctrl_nw = (ctrl_rd & ~bm) | (wb_dat_i & bm);
   wire [31:0] disp_nw = (disp_rd & ~bm) | (wb_dat_i & bm);
   wire [2:0] nw_d1 = disp_nw[lam_pkg::DISP_D1_LSB +: 3];
   wire [2:0] nw_d2 = disp_nw[lam_pkg::DISP_D2_LSB +: 3];
   // a write carrying an unlisted code is dropped whole
   wire disp_ok = nw_d1 <= lam_pkg::SHOW_AMBIENT_TEMPERATURE
      && nw_d2 <= lam_pkg::SHOW_NOTHING;
   wire wr_ctrl = wr && wb_adr_i == lam_pkg::REG_CTRL;
   wire wr_disp = wr && wb_adr_i == lam_pkg::REG_DISP && !wp_q
      && disp_ok;
   wire [1:0] vidx = 2'((wb_adr_i - lam_pkg::REG_VAL0) >> 2);
   wire is_val = wb_adr_i >= lam_pkg::REG_VAL0
      && wb_adr_i < lam_pkg::REG_DISP && wb_adr_i[1:0] == 2'b00;
   wire [31:0] rd_mux =
      wb_adr_i == lam_pkg::REG_CTRL ? ctrl_rd :
      wb_adr_i == lam_pkg::REG_STAT ? stat_rd :
      wb_adr_i == lam_pkg::REG_DISP ? disp_rd :
      is_val ? {16'h0, val_q[vidx]} : 32'h0;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         en_q <= lam_pkg::CTRL_EN_RST;
         wp_q <= lam_pkg::CTRL_WP_RST;
      end
      else if (ce_i)
      begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_mux : 32'h0;
         if (wr_ctrl)
         begin
            en_q <= ctrl_nw[lam_pkg::CTRL_EN_BIT];
            wp_q <= ctrl_nw[lam_pkg::CTRL_WP_BIT];
         end
      end
   end

   // ---------------------------------------------------------
   // settings, live in volatile flops until saved
   // ---------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         d1_q <= lam_pkg::SHOW_OUTPUT_CURRENT;
         d2_q <= lam_pkg::SHOW_NOTHING;
         unit_q <= lam_pkg::UNIT_RST;
      end
      else if (ce_i)
      begin
         if (wr_disp)
         begin
            d1_q <= lam_pkg::lam_disp_t'(nw_d1);
            d2_q <= lam_pkg::lam_disp_t'(nw_d2);
            unit_q <= disp_nw[lam_pkg::DISP_UNIT_LSB +: 8];
         end
         else if (commit && is_d1)
            d1_q <= cand_q;
         else if (commit && is_d2)
            d2_q <= cand_q;
      end
   end
   for (genvar i = 0; i < 4; i++)
   begin : g_val
      wire hit = ramp_tick && !wp_q && ridx == 2'(i);
      wire wrv = wr && is_val && vidx == 2'(i) && !wp_q;
      wire [15:0] wv = (val_q[i] & ~bm[15:0]) | (wb_dat_i[15:0] & bm[15:0]);
      // out-of-limit remote values are refused so the ramps stay bounded
      wire wok = wv >= VAL_MIN[i] && wv <= VAL_MAX[i];
      wire inc = hit && rup && val_q[i] < VAL_MAX[i];
      wire dec = hit && !rup && val_q[i] > VAL_MIN[i];
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            val_q[i] <= lam_pkg::VAL_RST[i];
         else if (ce_i)
         begin
            if (wrv && wok)
               val_q[i] <= wv;
            else if (inc)
               val_q[i] <= val_q[i] + 16'h1;
            else if (dec)
               val_q[i] <= val_q[i] - 16'h1;
         end
      end
   end
   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign settings_o = {unit_q, d1_q, d2_q, val_q};
   wire alt_end = alt_q == 32'(ALT_CYC - 1);
   wire two = d2_q != lam_pkg::SHOW_NOTHING;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nvm_save_o <= 1'b0;
         nvm_data_o <= '0;
         menu_active_o <= 1'b0;
         menu_pos_o <= lam_pkg::POS_UNITS;
         choosing_o <= 1'b0;
         choice_o <= lam_pkg::SHOW_OUTPUT_CURRENT;
         numeric_o <= 16'h0;
         numeric_valid_o <= 1'b0;
         disp_show_o <= lam_pkg::SHOW_OUTPUT_CURRENT;
         alt_q <= 32'h0;
         slot_q <= 1'b0;
      end
      else if (ce_i)
      begin
         nvm_save_o <= do_save;
         if (do_save)
            nvm_data_o <= settings_o;
         menu_active_o <= mode_d != lam_pkg::MODE_IDLE;
         menu_pos_o <= pos_d;
         choosing_o <= mode_d == lam_pkg::MODE_CHOOSE;
         choice_o <= cand_d;
         numeric_o <= val_q[ridx];
         numeric_valid_o <= in_menu && is_ramp;
         alt_q <= alt_end ? 32'h0 : alt_q + 32'h1;
         slot_q <= alt_end ? !slot_q && two : slot_q && two;
         disp_show_o <= (slot_q && two) ? d2_q : d1_q;
      end
   end

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_wb_ack_due: assert property (ce_i && req |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_menu_entry: assert property (
      ce_i && in_idle && ev_b |=> in_menu && pos_q == lam_pkg::POS_UNITS)
      else $error("browse did not enter the menu");
   a_order_wrap: assert property (
      ce_i && in_menu && ev_b && at_exit |=> pos_q == lam_pkg::POS_UNITS)
      else $error("exit did not wrap to units");
   a_exit_idle: assert property (
      ce_i && in_menu && ev_s && at_exit |=> in_idle ##1 !menu_active_o)
      else $error("exit select did not leave the menu");
   a_disabled_idle: assert property (ce_i && !en_q |=> in_idle)
      else $error("menu active while local adjust off");
   a_wp_freeze: assert property (
      ce_i && wp_q |=> $stable(val_q) && $stable(d1_q) && $stable(d2_q))
      else $error("protected setting changed");
   a_ramp_up: assert property (
      ce_i && ramp_tick && !wp_q && pos_q == lam_pkg::POS_LRV_UP
      && val_q[0] < VAL_MAX[0] && !(wr && is_val)
      |=> val_q[0] == $past(val_q[0]) + 16'h1)
      else $error("lower range did not step up");
   a_ramp_bound: assert property (
      val_q[2] >= VAL_MIN[2] && val_q[2] <= VAL_MAX[2])
      else $error("probe length out of limits");
   a_save_once: assert property (
      ce_i && do_save |=> nvm_save_o ##1 !nvm_save_o || do_save)
      else $error("save pulse malformed");

   c_enter: cover property (in_idle ##1 in_menu);
   c_commit: cover property (commit && is_d2);
   c_ramp: cover property (ramp_tick ##[1:1000] ramp_tick);
   c_save: cover property (nvm_save_o);
endmodule
`default_nettype wire

/* File: verif/lam_tool_model.sv */
// lam_tool_model: hand-held magnet over the browse and select reeds
// assumes the bench calls touch() from one process only
`timescale 1ns/1ps
`default_nettype none
module lam_tool_model (
   input wire logic clk_i,
   output logic browse_o,
   output logic select_o
);
   initial
   begin
      browse_o = 1'h0;
      select_o = 1'h0;
   end
   // one magnet: one reed at a time, with contact bounce at touch
   task automatic touch(input logic sel, input int hold);
      repeat (3)
      begin
         @(posedge clk_i);
         if (sel)
            select_o <= ~select_o;
         else
            browse_o <= ~browse_o;
      end
      repeat (hold) @(posedge clk_i);
      browse_o <= 1'h0;
      select_o <= 1'h0;
      repeat (16) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* File: verif/lam_menu_test.sv */
// lam_menu_test: self-checking bench of the local adjust menu
// assumes short timing parameters and the tool model as switch driver
`timescale 1ns/1ps
`default_nettype none
module lam_menu_test;
   localparam logic [3:0][15:0] VMIN =
      {16'h0BA4, 16'h0BA4, 16'h03D4, 16'h0000};
   localparam logic [3:0][15:0] VMAX =
      {16'h0BCC, 16'h0BCC, 16'h03FC, 16'h0014};
   logic clk, rst, cyc, stb, we, ack, nsave, bsw, ssw, nval, ce, act;
   logic [7:0] adr;
   logic [3:0] bsel, wsel;
   lam_pkg::lam_pos_t pos;
   logic [31:0] wdat, rdat, raw;
   logic [15:0] num;
   logic [63:0] e;
   lam_pkg::lam_settings_t sets, nvd, exp_s;
   lam_pkg::lam_disp_t shown;
   logic [63:0] rq[$];
   lam_pkg::lam_settings_t sq[$];
   int n_fail, cmp_count, cur, i, j, n, c, code, a1, a2, v;
   int cnt[3];
   bit in_menu;
   lam_menu #(.ADV_CYC(50), .STEP_CYC(5), .DEB_CYC(4), .ALT_CYC(20),
      .VAL_MIN(VMIN), .VAL_MAX(VMAX)) i_lam_menu (.clk_i(clk),
      .rst_i(rst), .ce_i(ce), .browse_sw_i(bsw), .select_sw_i(ssw),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .settings_o(sets), .nvm_save_o(nsave), .nvm_data_o(nvd),
      .menu_active_o(act), .menu_pos_o(pos), .choosing_o(), .choice_o(),
      .numeric_o(num), .numeric_valid_o(nval), .disp_show_o(shown));
   lam_tool_model i_lam_tool_model (.clk_i(clk), .browse_o(bsw),
      .select_o(ssw));
   // ----------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------
   task automatic chk(input logic [127:0] seen, input logic [127:0] ex);
      cmp_count++;
      if (seen !== ex)
      begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, ex);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // reads note the masked expectation; the monitor compares at ack
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [31:0] m);
      if (!w)
         rq.push_back({m, d & m});
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      bsel <= wsel;
      do @(posedge clk); while (ack !== 1'h1);
      raw = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask
   task automatic go(input int p);
      if (!in_menu)
      begin
         i_lam_tool_model.touch(1'h0, 8);
         in_menu = 1;
         cur = 0;
      end
      while (cur != p)
      begin
         i_lam_tool_model.touch(1'h0, 8);
         cur = (cur + 1) % 13;
      end
   endtask
   function automatic logic [31:0] dw();
      return {16'h0, exp_s.units, 1'h0, exp_s.second_display_select,
         1'h0, exp_s.first_display_select};
   endfunction
   always @(posedge clk)
   begin
      if (ack === 1'h1 && we === 1'h0)
      begin
         e = rq.pop_front();
         chk(rdat & e[63:32], e[31:0]);
      end
      if (nsave === 1'h1)
         chk(nvd, sq.pop_front());
   end
   // ----------------------------------------------------------
   // clock, watchdog and tests
   // ----------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      #(20000 * 100);
      n_fail++;
      conclude();
   end
   initial
   begin
      rst = 1'h1;
      {cyc, stb, we, adr, wdat, bsel} = '0;
      wsel = 4'hF;
      ce = 1'h1;
      void'($urandom(70733));
      exp_s.units = 8'h00;
      exp_s.first_display_select = lam_pkg::SHOW_OUTPUT_CURRENT;
      exp_s.second_display_select = lam_pkg::SHOW_NOTHING;
      exp_s.val = lam_pkg::VAL_RST;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      bus(1'h0, lam_pkg::REG_CTRL, 32'h1, 32'h3);
      for (i = 0; i < 4; i++)
         bus(1'h0, 8'(lam_pkg::REG_VAL0 + 4 * i), {16'h0, exp_s.val[i]},
            32'hFFFFFFFF);
      bus(1'h0, lam_pkg::REG_DISP, dw(), 32'hFFFFFFFF);
      bus(1'h0, 8'h40, 32'h0, 32'hFFFFFFFF);
      $display("test reset values done");
      for (int k = 0; k < 14; k++)
      begin
         go(k % 13);
         bus(1'h0, lam_pkg::REG_STAT, (32'(k % 13) << 4) | 32'h1,
            32'hF1);
         chk({act, pos}, {1'h1, 4'(k % 13)});
      end
      // frozen clock enable: a browse touch must leave no trace
      ce <= 1'h0;
      i_lam_tool_model.touch(1'h0, 8);
      ce <= 1'h1;
      bus(1'h0, lam_pkg::REG_STAT, 32'h1, 32'hF1);
      $display("test browse order done");
      for (int t = 0; t < 13; t++)
      begin
         j = t < 6 ? 0 : 1;
         n = 6 + j;
         code = t - 6 * j;
         go(1 + j);
         i_lam_tool_model.touch(1'h1, 8);
         bus(1'h0, lam_pkg::REG_STAT, 32'h2, 32'h2);
         c = int'(raw[10:8]);
         repeat ((code - c + 2 * n) % n) i_lam_tool_model.touch(1'h0, 8);
         i_lam_tool_model.touch(1'h1, 8);
         if (j == 0)
            exp_s.first_display_select = lam_pkg::lam_disp_t'(code);
         else
            exp_s.second_display_select = lam_pkg::lam_disp_t'(code);
         bus(1'h0, lam_pkg::REG_DISP, dw(), 32'hFFFFFFFF);
      end
      $display("test display choice done");
      a1 = $urandom % 6;
      a2 = (a1 + 1 + $urandom % 5) % 6;
      for (int r = 0; r < 2; r++)
      begin
         exp_s.first_display_select = lam_pkg::lam_disp_t'(a1);
         exp_s.second_display_select = lam_pkg::lam_disp_t'(r ? 6 : a2);
         bus(1'h1, lam_pkg::REG_DISP, dw(), 32'h0);
         cnt = '{0, 0, 0};
         repeat (45) @(posedge clk);
         repeat (80)
         begin
            @(posedge clk);
            if (shown === exp_s.first_display_select)
               cnt[0]++;
            else if (shown === exp_s.second_display_select)
               cnt[1]++;
            else
               cnt[2]++;
         end
         chk({cnt[0] > 0, cnt[1] > 0, cnt[2]}, {1'h1, r == 0, 32'h0});
      end
      $display("test indicator done");
      for (int k = 0; k < 8; k++)
      begin
         i = k / 2;
         go(3 + k);
         repeat (4) @(posedge clk);
         chk({nval, num}, {1'h1, exp_s.val[i]});
         i_lam_tool_model.touch(1'h1, 260);
         exp_s.val[i] = k % 2 ? VMIN[i] : VMAX[i];
         bus(1'h0, 8'(lam_pkg::REG_VAL0 + 4 * i), {16'h0, exp_s.val[i]},
            32'hFFFFFFFF);
         chk(sets.val[i], exp_s.val[i]);
      end
      $display("test ramps done");
      go(11);
      sq.push_back(exp_s);
      i_lam_tool_model.touch(1'h1, 8);
      chk(sq.size(), 0);
      go(12);
      i_lam_tool_model.touch(1'h1, 8);
      in_menu = 0;
      bus(1'h0, lam_pkg::REG_STAT, 32'h0, 32'h1);
      i_lam_tool_model.touch(1'h0, 125);
      bus(1'h0, lam_pkg::REG_STAT, 32'h21, 32'hF1);
      bus(1'h1, lam_pkg::REG_CTRL, 32'h0, 32'h0);
      i_lam_tool_model.touch(1'h0, 8);
      bus(1'h0, lam_pkg::REG_STAT, 32'h0, 32'h1);
      $display("test save exit enable done");
      v = 1 + $urandom % 20;
      bus(1'h1, lam_pkg::REG_CTRL, 32'h3, 32'h0);
      bus(1'h1, lam_pkg::REG_VAL0, 32'(v), 32'h0);
      bus(1'h0, lam_pkg::REG_VAL0, {16'h0, exp_s.val[0]}, 32'hFFFF);
      bus(1'h1, lam_pkg::REG_CTRL, 32'h1, 32'h0);
      // byte lane zero only: the upper ones bits must not land
      wsel = 4'h1;
      bus(1'h1, lam_pkg::REG_VAL0, 32'hFFFFFF00 | 32'(v), 32'h0);
      wsel = 4'hF;
      bus(1'h0, lam_pkg::REG_VAL0, 32'(v), 32'hFFFF);
      $display("test write protect done");
      conclude();
   end
endmodule
`default_nettype wire
